// *** core/mdlc_defines.svh ***
// Register offsets, reset values and timing constants of the modem line control block
`ifndef MDLC_DEFINES_SVH
`define MDLC_DEFINES_SVH

// APB byte offsets
`define MDLC_OFS_CTRL     12'h000
`define MDLC_OFS_TRDLY    12'h004
`define MDLC_OFS_RCDLY    12'h008
`define MDLC_OFS_CDREC    12'h00c
`define MDLC_OFS_CLHUP    12'h010
`define MDLC_OFS_TONESPD  12'h014
`define MDLC_OFS_STATUS   12'h018
`define MDLC_OFS_CMD      12'h01c

// Control register fields
`define MDLC_CTRL_TR_LSB  0
`define MDLC_CTRL_DS_LSB  2
`define MDLC_CTRL_RTS_BIT 4

// Command register bits
`define MDLC_CMD_DIAL     0
`define MDLC_CMD_REVERSE  1
`define MDLC_CMD_HANDDONE 2
`define MDLC_CMD_ONLINE   3
`define MDLC_CMD_HANGUP   4

// Reset values of the delay registers
`define MDLC_RST_TRDLY    8'h05
`define MDLC_RST_RCDLY    8'h01
`define MDLC_RST_CDREC    8'h06
`define MDLC_RST_CLHUP    8'h0e
`define MDLC_RST_TONESPD  8'h46

// Hang-up register value that disables hang-up on carrier loss
`define MDLC_CLHUP_NEVER  8'hff

// Time units: 10 ms per delay tick at 10 MHz (100 ns period)
`define MDLC_TICK_NS      10000000
`define MDLC_CLK_NS       100
`define MDLC_TICK_CYC     (`MDLC_TICK_NS / `MDLC_CLK_NS)

`endif

// *** core/mdlc_pkg.sv ***
// Types of the modem line control block
package mdlc_pkg;

   typedef enum logic [1:0] {
      MDLC_TR_IGNORE,
      MDLC_TR_CMD,
      MDLC_TR_RSV2,
      MDLC_TR_RSV3
   } mdlc_tr_e;

   typedef enum logic [1:0] {
      MDLC_DS_ALWAYS,
      MDLC_DS_EARLY,
      MDLC_DS_AFTER,
      MDLC_DS_RSV3
   } mdlc_ds_e;

   typedef enum logic [2:0] {
      MDLC_ST_CMD,
      MDLC_ST_DIAL,
      MDLC_ST_HANDSHAKE,
      MDLC_ST_CONNECTED,
      MDLC_ST_ONLINE
   } mdlc_state_e;

   typedef struct packed {
      logic [7:0] trdly;
      logic [7:0] rcdly;
      logic [7:0] cdrec;
      logic [7:0] clhup;
      logic [7:0] tonespd;
   } mdlc_cfg_s;

   typedef struct packed {
      logic dtr;
      logic rts;
      logic carrier;
   } mdlc_pins_s;

endpackage

// *** core/mdlc_top.sv ***
// Modem terminal-side line control: DTR, DSR, RTS/CTS, carrier timing, tone pacing, APB registers
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - Terminal-ready option zero: DTR changes cause no action.
// - Terminal-ready option one: DTR on-to-off drops online mode to command state.
// - DTR changes recognised only after terminal-ready delay register time.
// - Data-set-ready option one: DSR asserted when handshake negotiation starts.
// - Data-set-ready option two: DSR after handshake completes, before CONNECT.
// - RTS ignore mode: CTS held asserted regardless of RTS.
// - CTS asserted after RTS plus request-to-clear delay register time.
// - Carrier detected after carrier present for carrier recovery register time.
// - Carrier loss waits hang-up register time; returning carrier keeps call.
// - Hang-up register 255 disables hang-up on carrier loss.
// - Tone digits paced by tone dial speed register value.
// - Reverse dial modifier runs handshake in answer mode.
`include "mdlc_defines.svh"

module mdlc_top (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire mdlc_pkg::mdlc_pins_s pins_in,
   output logic                   dsr,
   output logic                   cts,
   output logic                   dcd,
   output logic                   off_hook,
   output logic                   answer_mode,
   output logic                   tone_on,
   output logic                   connect_evt
);
   import mdlc_pkg::*;

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   mdlc_pins_s pins_m_q;
   mdlc_pins_s pins_s_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         pins_m_q <= '0;
         pins_s_q <= '0;
      end else begin
         pins_m_q <= pins_in;
         pins_s_q <= pins_m_q;
      end
   end

   // ------------------------------------------------------------------
   // Time base
   // ------------------------------------------------------------------
   // One tick per 10 ms, shared by every delay so all counts use the same unit
   localparam int TICK_CYC = `MDLC_TICK_CYC;
   logic [16:0] pre_q;
   logic        tick;

   assign tick = (pre_q == 17'(TICK_CYC - 1));

   always_ff @(posedge clk) begin
      if (rst || tick) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 17'h00001;
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic [1:0]  tr_mode_q;
   logic [1:0]  ds_mode_q;
   logic        rts_ign_q;
   mdlc_cfg_s   cfg_q;
   logic        cmd_dial;
   logic        cmd_rev;
   logic        cmd_hsdone;
   logic        cmd_online;
   logic        cmd_hangup;
   logic        wr_en;
   logic        rd_en;

   function automatic logic addr_known(input logic [11:0] a);
      case (a)
         `MDLC_OFS_CTRL, `MDLC_OFS_TRDLY, `MDLC_OFS_RCDLY, `MDLC_OFS_CDREC,
         `MDLC_OFS_CLHUP, `MDLC_OFS_TONESPD, `MDLC_OFS_STATUS, `MDLC_OFS_CMD: addr_known = 1'b1;
         default: addr_known = 1'b0;
      endcase
   endfunction

   // Zero-wait slave: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_known(paddr);
   assign wr_en   = psel && penable && pwrite && addr_known(paddr);
   assign rd_en   = psel && !penable && !pwrite;

   // Command bits are strobes: they act in the write cycle; only the reverse bit is kept, in ans_q on a dial
   function automatic logic cmd_hit(input logic [11:0] a, input logic [31:0] d, input int unsigned b);
      cmd_hit = (a == `MDLC_OFS_CMD) && d[b];
   endfunction

   assign cmd_dial   = wr_en && cmd_hit(paddr, pwdata, `MDLC_CMD_DIAL);
   assign cmd_rev    = pwdata[`MDLC_CMD_REVERSE];
   assign cmd_hsdone = wr_en && cmd_hit(paddr, pwdata, `MDLC_CMD_HANDDONE);
   assign cmd_online = wr_en && cmd_hit(paddr, pwdata, `MDLC_CMD_ONLINE);
   assign cmd_hangup = wr_en && cmd_hit(paddr, pwdata, `MDLC_CMD_HANGUP);

   always_ff @(posedge clk) begin
      if (rst) begin
         tr_mode_q     <= MDLC_TR_IGNORE;
         ds_mode_q     <= MDLC_DS_ALWAYS;
         rts_ign_q     <= 1'b0;
         cfg_q.trdly   <= `MDLC_RST_TRDLY;
         cfg_q.rcdly   <= `MDLC_RST_RCDLY;
         cfg_q.cdrec   <= `MDLC_RST_CDREC;
         cfg_q.clhup   <= `MDLC_RST_CLHUP;
         cfg_q.tonespd <= `MDLC_RST_TONESPD;
      end else if (wr_en) begin
         case (paddr)
            `MDLC_OFS_CTRL: begin
               tr_mode_q <= pwdata[`MDLC_CTRL_TR_LSB +: 2];
               ds_mode_q <= pwdata[`MDLC_CTRL_DS_LSB +: 2];
               rts_ign_q <= pwdata[`MDLC_CTRL_RTS_BIT];
            end
            `MDLC_OFS_TRDLY:   cfg_q.trdly   <= pwdata[7:0];
            `MDLC_OFS_RCDLY:   cfg_q.rcdly   <= pwdata[7:0];
            `MDLC_OFS_CDREC:   cfg_q.cdrec   <= pwdata[7:0];
            `MDLC_OFS_CLHUP:   cfg_q.clhup   <= pwdata[7:0];
            `MDLC_OFS_TONESPD: cfg_q.tonespd <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Delay filters for DTR, RTS and carrier
   // ------------------------------------------------------------------
   // Each input must hold a new level for its delay before the filtered copy follows
   logic [2:0] raw;
   logic [2:0] filt_q;
   logic [7:0] dly_on  [3];
   logic [7:0] dly_off [3];
   logic [7:0] fcnt_q  [3];
   logic       hup_never;

   assign raw        = {pins_s_q.carrier, pins_s_q.rts, pins_s_q.dtr};
   assign hup_never  = (cfg_q.clhup == `MDLC_CLHUP_NEVER);
   assign dly_on[0]  = cfg_q.trdly;
   assign dly_off[0] = cfg_q.trdly;
   assign dly_on[1]  = cfg_q.rcdly;
   assign dly_off[1] = 8'h00;
   assign dly_on[2]  = cfg_q.cdrec;
   assign dly_off[2] = hup_never ? 8'h00 : cfg_q.clhup;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_filt
         always_ff @(posedge clk) begin
            if (rst) begin
               filt_q[gi] <= 1'b0;
               fcnt_q[gi] <= '0;
            end else if (raw[gi] == filt_q[gi]) begin
               fcnt_q[gi] <= '0;
            end else if ((raw[gi] ? dly_on[gi] : dly_off[gi]) <= fcnt_q[gi]) begin
               filt_q[gi] <= raw[gi];
               fcnt_q[gi] <= '0;
            end else if (tick) begin
               fcnt_q[gi] <= fcnt_q[gi] + 8'h01;
            end
         end
      end
   endgenerate

   logic dtr_f_d1_q;
   logic dtr_fall;
   logic car_lost;

   always_ff @(posedge clk) begin
      if (rst) begin
         dtr_f_d1_q <= 1'b0;
      end else begin
         dtr_f_d1_q <= filt_q[0];
      end
   end

   assign dtr_fall = dtr_f_d1_q && !filt_q[0];
   // Carrier loss only ends the call when the hang-up register does not say never
   assign car_lost = !filt_q[2] && !hup_never;

   // ------------------------------------------------------------------
   // Call state
   // ------------------------------------------------------------------
   mdlc_state_e st_q;
   logic        ans_q;
   logic        conn_q;
   logic        tone_done;

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q   <= MDLC_ST_CMD;
         ans_q  <= 1'b0;
         conn_q <= 1'b0;
      end else begin
         conn_q <= 1'b0;
         if (cmd_hangup) begin
            st_q <= MDLC_ST_CMD;
         end else begin
            case (st_q)
               MDLC_ST_CMD: begin
                  if (cmd_dial) begin
                     st_q  <= MDLC_ST_DIAL;
                     ans_q <= cmd_rev;
                  end else if (cmd_online && filt_q[2]) begin
                     st_q <= MDLC_ST_ONLINE;
                  end
               end
               MDLC_ST_DIAL: begin
                  if (tone_done) begin
                     st_q <= MDLC_ST_HANDSHAKE;
                  end
               end
               MDLC_ST_HANDSHAKE: begin
                  if (cmd_hsdone && filt_q[2]) begin
                     st_q <= MDLC_ST_CONNECTED;
                  end
               end
               MDLC_ST_CONNECTED: begin
                  // DSR is up by the end of this cycle; CONNECT follows one cycle later
                  st_q   <= MDLC_ST_ONLINE;
                  conn_q <= 1'b1;
               end
               MDLC_ST_ONLINE: begin
                  if (car_lost) begin
                     st_q <= MDLC_ST_CMD;
                  end else if ((tr_mode_q == MDLC_TR_CMD) && dtr_fall) begin
                     st_q <= MDLC_ST_CMD;
                  end
               end
               default: st_q <= MDLC_ST_CMD;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Tone dial pacing
   // ------------------------------------------------------------------
   // One tone then one gap per dial command, each lasting the tone speed value plus one in ticks
   logic [7:0] tcnt_q;
   logic       tphase_q;

   assign tone_done = (st_q == MDLC_ST_DIAL) && tphase_q && tick && (tcnt_q >= cfg_q.tonespd);

   always_ff @(posedge clk) begin
      if (rst || st_q != MDLC_ST_DIAL) begin
         tcnt_q   <= '0;
         tphase_q <= 1'b0;
      end else if (tick) begin
         if (tcnt_q >= cfg_q.tonespd) begin
            tcnt_q   <= '0;
            tphase_q <= ~tphase_q;
         end else begin
            tcnt_q <= tcnt_q + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   logic dsr_d;

   always_comb begin
      case (ds_mode_q)
         MDLC_DS_ALWAYS: dsr_d = 1'b1;
         MDLC_DS_EARLY:  dsr_d = (st_q == MDLC_ST_HANDSHAKE) || (st_q == MDLC_ST_CONNECTED)
                                 || (st_q == MDLC_ST_ONLINE);
         MDLC_DS_AFTER:  dsr_d = (st_q == MDLC_ST_CONNECTED) || (st_q == MDLC_ST_ONLINE);
         default:        dsr_d = 1'b1;
      endcase
   end

   // Handshake lines toward the host
   always_ff @(posedge clk) begin
      if (rst) begin
         dsr <= 1'b0;
         cts <= 1'b0;
         dcd <= 1'b0;
      end else begin
         dsr <= dsr_d;
         cts <= rts_ign_q ? 1'b1 : filt_q[1];
         dcd <= filt_q[2];
      end
   end

   // ------------------------------------------------------------------
   // Call indications
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         off_hook    <= 1'b0;
         answer_mode <= 1'b0;
         tone_on     <= 1'b0;
         connect_evt <= 1'b0;
      end else begin
         off_hook    <= (st_q != MDLC_ST_CMD);
         answer_mode <= ans_q && (st_q != MDLC_ST_CMD);
         tone_on     <= (st_q == MDLC_ST_DIAL) && !tphase_q;
         connect_evt <= conn_q;
      end
   end

   // ------------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------------
   // Loaded in the setup cycle, so the word stands through the access cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= '0;
      end else if (rd_en) begin
         case (paddr)
            `MDLC_OFS_CTRL:    prdata <= {27'h0, rts_ign_q, ds_mode_q, tr_mode_q};
            `MDLC_OFS_TRDLY:   prdata <= {24'h0, cfg_q.trdly};
            `MDLC_OFS_RCDLY:   prdata <= {24'h0, cfg_q.rcdly};
            `MDLC_OFS_CDREC:   prdata <= {24'h0, cfg_q.cdrec};
            `MDLC_OFS_CLHUP:   prdata <= {24'h0, cfg_q.clhup};
            `MDLC_OFS_TONESPD: prdata <= {24'h0, cfg_q.tonespd};
            `MDLC_OFS_STATUS:  prdata <= {24'h0, filt_q, ans_q, 1'b0, st_q};
            default:           prdata <= '0;
         endcase
      end
   end

endmodule // mdlc_top

// *** bench/mdlc_top_sva.sv ***
// Port assertions of the modem line control block
`timescale 1ns/1ps
module mdlc_chk (
   input wire logic                 clk,
   input wire logic                 rst,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [11:0]          paddr,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire mdlc_pkg::mdlc_pins_s pins_in,
   input wire logic                 dsr,
   input wire logic                 dcd,
   input wire logic                 off_hook,
   input wire logic                 answer_mode,
   input wire logic                 tone_on,
   input wire logic                 connect_evt
);
   import mdlc_pkg::*;
   logic acc;
   logic bad;
   assign acc = psel && penable;
   // Only aligned words below 0x20 are mapped
   assign bad = paddr[11:5] != 7'h00 || paddr[1:0] != 2'h0;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_rdy; acc |-> pready; endproperty
   property p_err; pslverr == (acc && bad); endproperty
   property p_rdz; acc && !pwrite && bad |-> prdata == 32'h0; endproperty
   property p_up; acc && !pwrite |-> prdata[31:8] == 24'h0; endproperty
   property p_rst0; $fell(rst) |-> !dsr && !off_hook && !dcd; endproperty
   property p_dsr; $fell(rst) |-> ##[1:3] dsr; endproperty
   property p_dcd; $rose(dcd) |-> $past(pins_in.carrier, 2); endproperty
   property p_tone; tone_on |-> off_hook; endproperty
   property p_ans; answer_mode |-> off_hook; endproperty
   property p_conn; connect_evt |-> dsr ##1 !connect_evt; endproperty
   a_rdy: assert property (p_rdy) else $error("pready low in access");
   a_err: assert property (p_err) else $error("pslverr wrong");
   a_rdz: assert property (p_rdz) else $error("unmapped read not zero");
   a_up: assert property (p_up) else $error("upper read bits set");
   a_rst0: assert property (p_rst0) else $error("outputs not clear after reset");
   a_dsr: assert property (p_dsr) else $error("dsr not raised after reset");
   a_dcd: assert property (p_dcd) else $error("dcd rose without carrier");
   a_tone: assert property (p_tone) else $error("tone while on hook");
   a_ans: assert property (p_ans) else $error("answer mode while on hook");
   a_conn: assert property (p_conn) else $error("connect without dsr");
   c_err: cover property (acc && bad);
   c_dcd: cover property ($rose(dcd));
   c_tone: cover property ($rose(tone_on));
endmodule // mdlc_chk

bind mdlc_top mdlc_chk mdlc_chk_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pins_in(pins_in), .dsr(dsr), .dcd(dcd), .off_hook(off_hook), .answer_mode(answer_mode),
   .tone_on(tone_on), .connect_evt(connect_evt));

// *** bench/mdlc_host.sv ***
// Host terminal and line model driving the pin levels
`timescale 1ns/1ps
module mdlc_host (
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic            dtr_req,
   input  wire logic            rts_req,
   input  wire logic            car_req,
   output mdlc_pkg::mdlc_pins_s pins
);
   import mdlc_pkg::*;
   // Levels move only after an edge, as a real port would
   always_ff @(posedge clk) begin
      if (rst) begin
         pins <= '0;
      end else begin
         pins.dtr     <= dtr_req;
         pins.rts     <= rts_req;
         pins.carrier <= car_req;
      end
   end
endmodule // mdlc_host

// *** bench/mdlc_top_tb_top.sv ***
// Self-checking bench of the modem line control block
`timescale 1ns/1ps
`include "mdlc_defines.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch %s exp %0h got %0h", n, e, g); end end
module mdlc_top_tb_top;
   import mdlc_pkg::*;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        dsr, cts, dcd, off_hook, answer_mode, tone_on, connect_evt;
   logic        dtr_q, rts_q, car_q;
   mdlc_pins_s  pins;
   int          n_mismatch, checked;

   mdlc_top mdlc_top_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pins_in(pins), .dsr(dsr), .cts(cts), .dcd(dcd), .off_hook(off_hook),
      .answer_mode(answer_mode), .tone_on(tone_on), .connect_evt(connect_evt));
   mdlc_host mdlc_host_inst (.clk(clk), .rst(rst), .dtr_req(dtr_q), .rts_req(rts_q),
      .car_req(car_q), .pins(pins));

   task automatic results();
      if (n_mismatch == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Idle cycle first, so psel never gets two assignments in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_mismatch++;
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic s_regs();
      logic [7:0] rv [6] = '{8'h00, 8'h05, 8'h01, 8'h06, 8'h0e, 8'h46};
      for (int k = 0; k < 6; k++) begin
         apb(1'b0, 12'(k * 4), 32'h0);
         `CHK("reset value", {24'h0, rv[k]}, rd)
      end
      `CHK("dsr default", 1'b1, dsr)
      apb(1'b1, `MDLC_OFS_CLHUP, 32'hffffffff);
      apb(1'b0, `MDLC_OFS_CLHUP, 32'h0);
      `CHK("hangup never", 32'h000000ff, rd)
      apb(1'b1, `MDLC_OFS_CLHUP, 32'h0000000e);
   endtask
   task automatic s_bad();
      apb(1'b0, 12'h020, 32'h0);
      `CHK("unmapped err", 1'b1, err)
      `CHK("unmapped data", 32'h0, rd)
      apb(1'b1, 12'h006, 32'h0);
      `CHK("misaligned err", 1'b1, err)
      apb(1'b1, `MDLC_OFS_STATUS, 32'hffffffff);
      apb(1'b0, `MDLC_OFS_STATUS, 32'h0);
      `CHK("status read only", 32'h0, rd)
      apb(1'b0, `MDLC_OFS_CMD, 32'h0);
      `CHK("cmd reads zero", 32'h0, rd)
   endtask
   task automatic s_cts();
      apb(1'b1, `MDLC_OFS_CTRL, 32'h10);
      cyc(10);
      `CHK("cts ignore", 1'b1, cts)
      apb(1'b1, `MDLC_OFS_CTRL, 32'h0);
      apb(1'b1, `MDLC_OFS_RCDLY, 32'h0);
      cyc(10);
      `CHK("cts idle", 1'b0, cts)
      rts_q <= 1'b1;
      cyc(10);
      `CHK("cts zero delay", 1'b1, cts)
      rts_q <= 1'b0;
      cyc(10);
      `CHK("cts drop", 1'b0, cts)
      // Two ticks, so a short first tick cannot end the wait
      apb(1'b1, `MDLC_OFS_RCDLY, 32'h2);
      rts_q <= 1'b1;
      cyc(300);
      `CHK("cts delayed", 1'b0, cts)
      rts_q <= 1'b0;
   endtask
   task automatic s_dcd();
      car_q <= 1'b1;
      cyc(300);
      `CHK("dcd delayed", 1'b0, dcd)
      apb(1'b1, `MDLC_OFS_CDREC, 32'h0);
      cyc(10);
      `CHK("dcd zero delay", 1'b1, dcd)
      apb(1'b0, `MDLC_OFS_STATUS, 32'h0);
      `CHK("status carrier", 1'b1, rd[7])
      car_q <= 1'b0;
      cyc(10);
      `CHK("dcd held", 1'b1, dcd)
      apb(1'b1, `MDLC_OFS_CLHUP, 32'h0);
      cyc(10);
      `CHK("dcd gone", 1'b0, dcd)
   endtask
   task automatic s_online();
      apb(1'b1, `MDLC_OFS_TRDLY, 32'h0);
      apb(1'b1, `MDLC_OFS_CDREC, 32'h0);
      apb(1'b1, `MDLC_OFS_CLHUP, 32'hff);
      dtr_q <= 1'b1;
      car_q <= 1'b1;
      cyc(10);
      apb(1'b1, `MDLC_OFS_CMD, 32'h08);
      apb(1'b0, `MDLC_OFS_STATUS, 32'h0);
      `CHK("online state", 3'h4, rd[2:0])
      dtr_q <= 1'b0;
      cyc(10);
      `CHK("dtr ignored", 1'b1, off_hook)
      car_q <= 1'b0;
      cyc(10);
      `CHK("never hang up", 1'b1, off_hook)
      apb(1'b1, `MDLC_OFS_CLHUP, 32'h0);
      cyc(10);
      `CHK("carrier hang up", 1'b0, off_hook)
      car_q <= 1'b1;
      dtr_q <= 1'b1;
      apb(1'b1, `MDLC_OFS_CTRL, 32'h1);
      cyc(10);
      apb(1'b1, `MDLC_OFS_CMD, 32'h08);
      cyc(10);
      `CHK("online again", 1'b1, off_hook)
      dtr_q <= 1'b0;
      cyc(10);
      `CHK("dtr drop", 1'b0, off_hook)
      apb(1'b1, `MDLC_OFS_CTRL, 32'h0);
      car_q <= 1'b0;
   endtask
   task automatic s_dtr();
      apb(1'b1, `MDLC_OFS_TRDLY, 32'h0);
      dtr_q <= 1'b1;
      cyc(10);
      apb(1'b0, `MDLC_OFS_STATUS, 32'h0);
      `CHK("dtr seen", 1'b1, rd[5])
      apb(1'b1, `MDLC_OFS_TRDLY, 32'h5);
      dtr_q <= 1'b0;
      cyc(300);
      apb(1'b0, `MDLC_OFS_STATUS, 32'h0);
      `CHK("dtr held", 1'b1, rd[5])
      `CHK("no dtr action", 3'h0, rd[2:0])
   endtask
   task automatic s_dsr();
      apb(1'b1, `MDLC_OFS_CTRL, 32'h08);
      cyc(10);
      `CHK("dsr late", 1'b0, dsr)
      apb(1'b1, `MDLC_OFS_CTRL, 32'h04);
      cyc(10);
      `CHK("dsr early idle", 1'b0, dsr)
      apb(1'b1, `MDLC_OFS_CTRL, 32'h0);
      cyc(10);
      `CHK("dsr always", 1'b1, dsr)
   endtask
   task automatic s_dial();
      apb(1'b1, `MDLC_OFS_CMD, 32'h03);
      cyc(10);
      `CHK("off hook", 1'b1, off_hook)
      `CHK("tone burst", 1'b1, tone_on)
      `CHK("answer mode", 1'b1, answer_mode)
      apb(1'b0, `MDLC_OFS_STATUS, 32'h0);
      `CHK("dial state", 3'h1, rd[2:0])
      `CHK("status answer", 1'b1, rd[4])
      apb(1'b1, `MDLC_OFS_CMD, 32'h10);
      cyc(10);
      `CHK("hung up", 1'b0, off_hook)
      `CHK("answer cleared", 1'b0, answer_mode)
      `CHK("tone off", 1'b0, tone_on)
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      dtr_q = 1'b0;
      rts_q = 1'b0;
      car_q = 1'b0;
      n_mismatch = 0;
      checked = 0;
      cyc(10);
      rst <= 1'b0;
      cyc(3);
      s_regs();
      s_bad();
      s_cts();
      s_dcd();
      s_dtr();
      s_online();
      s_dsr();
      s_dial();
      results();
   end
endmodule // mdlc_top_tb_top
